// *** sim/adc_window_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none

module adc_window_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire adc_window_pkg::reg_req_type req,
    input wire logic [adc_window_pkg::DATA_W-1:0] rdata,
    // Results and flags
    input wire adc_window_pkg::result_type result,
    input wire logic window_match_flag,
    input wire logic irq
);
    import adc_window_pkg::*;

    logic [15:0] gt_sh, lt_sh, res_sh;
    logic [7:0] exp_rd;
    logic [1:0] en_sh;
    logic mode_sh, pend, rd_q, known_q, above, below, ordered, hit, ctl_wr, ctl_set;

    ////////////////////////////////////////////////////////////////////////
    // Shadow of stored words, so expected read data comes from writes and result loads only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gt_sh <= GREATER_RESET;
            lt_sh <= LESSER_RESET;
            res_sh <= RESULT_RESET;
            mode_sh <= 1'h0;
            en_sh <= 2'h0;
            pend <= 1'h0;
            rd_q <= 1'h0;
            known_q <= 1'h0;
            exp_rd <= 8'h00;
        end else begin
            pend <= result.valid;
            rd_q <= req.rd;
            known_q <= 1'h1;
            if (result.valid) begin
                res_sh <= result.word;
            end
            case (req.addr)
                OFF_RESULT_HIGH: exp_rd <= res_sh[15:8];
                OFF_RESULT_LOW: exp_rd <= res_sh[7:0];
                OFF_GREATER_HIGH: exp_rd <= gt_sh[15:8];
                OFF_GREATER_LOW: exp_rd <= gt_sh[7:0];
                OFF_LESSER_HIGH: exp_rd <= lt_sh[15:8];
                OFF_LESSER_LOW: exp_rd <= lt_sh[7:0];
                default: known_q <= 1'h0;
            endcase
            if (req.wr) begin
                case (req.addr)
                    OFF_GREATER_HIGH: gt_sh[15:8] <= req.wdata;
                    OFF_GREATER_LOW: gt_sh[7:0] <= req.wdata;
                    OFF_LESSER_HIGH: lt_sh[15:8] <= req.wdata;
                    OFF_LESSER_LOW: lt_sh[7:0] <= req.wdata;
                    OFF_MODE: mode_sh <= req.wdata[MODE_SIGNED_BIT];
                    OFF_IRQ_ENABLE: en_sh <= req.wdata[1:0];
                    default: ;
                endcase
            end
        end
    end

    // Expected verdict for the result under evaluation
    always_comb begin
        above = mode_sh ? ($signed(res_sh) > $signed(gt_sh)) : (res_sh > gt_sh);
        below = mode_sh ? ($signed(res_sh) < $signed(lt_sh)) : (res_sh < lt_sh);
        ordered = mode_sh ? ($signed(gt_sh) < $signed(lt_sh)) : (gt_sh < lt_sh);
        hit = pend && (ordered ? (above && below) : (above || below));
        ctl_wr = req.wr && (req.addr == OFF_CONTROL);
        ctl_set = ctl_wr && req.wdata[CTRL_MATCH_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    unsigned_match_a: assert property (hit && !mode_sh |=> window_match_flag)
        else $error("unsigned match not flagged");
    signed_match_a: assert property (hit && mode_sh |=> window_match_flag)
        else $error("signed match not flagged");
    flag_cause_a: assert property (
        $rose(window_match_flag) |-> $past(hit) || $past(ctl_set, 2))
        else $error("match flag rose without cause");
    flag_sticky_a: assert property (
        window_match_flag && !ctl_wr && !$past(ctl_wr) |=> window_match_flag)
        else $error("match flag dropped on its own");
    irq_rise_a: assert property (hit && en_sh[IRQ_MATCH_BIT] |-> ##2 irq)
        else $error("enabled match raised no interrupt");
    irq_mask_a: assert property (irq |-> $past(en_sh) != 2'h0)
        else $error("interrupt while all sources masked");
    rdata_idle_a: assert property (!rd_q |-> rdata == READ_ZERO)
        else $error("read data not zero outside a read");
    read_back_a: assert property (rd_q && known_q |-> rdata == exp_rd)
        else $error("read data differs from stored word");

    cover property (hit && mode_sh);
    cover property (hit && !mode_sh && !ordered);
    cover property (irq);
endmodule

bind adc_window_detector adc_window_monitor adc_window_monitor_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .req(req),
    .rdata(rdata),
    .result(result),
    .window_match_flag(window_match_flag),
    .irq(irq)
);

`default_nettype wire

// *** sim/conversion_source.sv ***
`timescale 1ns/1ns
`default_nettype none

module conversion_source (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Command from the bench
    input wire logic start,
    input wire logic [15:0] start_word,
    input wire logic [3:0] delay,
    // Result towards the detector
    output var adc_window_pkg::result_type result
);
    import adc_window_pkg::*;

    logic [15:0] held;
    logic [4:0] count;

    ////////////////////////////////////////////////////////////////////////
    // Conversion pacing, delay 0 answers in the second cycle after start
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= 5'h00;
            held <= 16'h0000;
        end else if (start) begin
            count <= {1'h0, delay} + 5'h01;
            held <= start_word;
        end else if (count != 5'h00) begin
            count <= count - 5'h01;
        end
    end

    // Word toggles outside valid so a stale value can never pass for a result
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result <= '0;
        end else if (count == 5'h01) begin
            result <= {1'h1, held};
        end else begin
            result <= {1'h0, ~result.word};
        end
    end
endmodule

`default_nettype wire

// *** sim/test_adc_window_detector.sv ***
`timescale 1ns/1ns
`default_nettype none

module test_adc_window_detector;
    import adc_window_pkg::*;

    typedef struct packed {
        logic [15:0] gt;
        logic [15:0] lt;
        logic md;
        logic [15:0] w;
        logic ex;
    } row_type;

    localparam int LIMIT = 2000;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    reg_req_type req = '0;
    logic [7:0] rdata;
    result_type result;
    logic window_match_flag, irq;
    logic start = 1'h0;
    logic [15:0] start_word = 16'h0000;
    logic [3:0] delay = 4'h0;
    logic [7:0] got;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    // Limits, mode and result beside the verdict they should give
    row_type rows [15] = '{
        '{16'h0040, 16'h0080, 1'h0, 16'h0041, 1'h1}, '{16'h0040, 16'h0080, 1'h0, 16'h0040, 1'h0},
        '{16'h0040, 16'h0080, 1'h0, 16'h0080, 1'h0}, '{16'h0040, 16'h0080, 1'h0, 16'h007F, 1'h1},
        '{16'h0080, 16'h0040, 1'h0, 16'h003F, 1'h1}, '{16'h0080, 16'h0040, 1'h0, 16'h0060, 1'h0},
        '{16'h0080, 16'h0040, 1'h0, 16'h0081, 1'h1}, '{16'h0080, 16'h0040, 1'h0, 16'h0080, 1'h0},
        '{16'hFFFF, 16'h0040, 1'h1, 16'h0000, 1'h1}, '{16'hFFFF, 16'h0040, 1'h1, 16'hFFFF, 1'h0},
        '{16'hFFFF, 16'h0040, 1'h1, 16'h0040, 1'h0}, '{16'hFFFF, 16'h0040, 1'h1, 16'hFFFE, 1'h0},
        '{16'h0040, 16'hFFFF, 1'h1, 16'hFE00, 1'h1}, '{16'h0040, 16'hFFFF, 1'h1, 16'h0041, 1'h1},
        '{16'h0040, 16'hFFFF, 1'h1, 16'h0000, 1'h0}};
    logic [7:0] reset_vals [12] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    adc_window_detector adc_window_detector_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .req(req),
        .rdata(rdata),
        .result(result),
        .window_match_flag(window_match_flag),
        .irq(irq)
    );

    conversion_source conversion_source_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(start),
        .start_word(start_word),
        .delay(delay),
        .result(result)
    );

    always #5 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////
    task end_sim;
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Strobe drops a cycle before the next request, never in the same step
    task bus_wr(input logic [3:0] a, input logic [7:0] d);
        req <= '{a, d, 1'h1, 1'h0};
        @(posedge sys_clk);
        req <= '{a, d, 1'h0, 1'h0};
        @(posedge sys_clk);
    endtask

    task bus_rd(input logic [3:0] a);
        req <= '{a, 8'h00, 1'h0, 1'h1};
        @(posedge sys_clk);
        req.rd <= 1'h0;
        @(posedge sys_clk);
        got = rdata;
    endtask

    task setup(input row_type r);
        bus_wr(OFF_GREATER_HIGH, r.gt[15:8]);
        bus_wr(OFF_GREATER_LOW, r.gt[7:0]);
        bus_wr(OFF_LESSER_HIGH, r.lt[15:8]);
        bus_wr(OFF_LESSER_LOW, r.lt[7:0]);
        bus_wr(OFF_MODE, {7'h00, r.md});
        bus_wr(OFF_CONTROL, 8'h00);
        bus_wr(OFF_IRQ_CLEAR, 8'h03);
    endtask

    // Returns where the flag of the evaluated result is settled
    task conv(input logic [15:0] w, input logic [3:0] d);
        start <= 1'h1;
        start_word <= w;
        delay <= d;
        @(posedge sys_clk);
        start <= 1'h0;
        for (int i = 0; i < 20 && result.valid !== 1'h1; i++) begin
            @(posedge sys_clk);
        end
        repeat (2) @(posedge sys_clk);
    endtask

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            end_sim;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        for (int a = 0; a < 12; a++) begin
            bus_rd(4'(a));
            check(16'(got), 16'(reset_vals[a]));
        end
        foreach (rows[n]) begin
            setup(rows[n]);
            conv(rows[n].w, 4'h0);
            check(16'(window_match_flag), 16'(rows[n].ex));
            bus_rd(OFF_CONTROL);
            check(16'(got[CTRL_MATCH_BIT]), 16'(rows[n].ex));
            check(16'(got[CTRL_DONE_BIT]), 16'h0001);
        end
        // Slow conversion, result bytes read back and refuse writes
        conv(16'h0123, 4'h5);
        bus_wr(OFF_RESULT_HIGH, 8'h55);
        bus_rd(OFF_RESULT_HIGH);
        check(16'(got), 16'h0001);
        bus_rd(OFF_RESULT_LOW);
        check(16'(got), 16'h0023);
        // Back-to-back results, a miss then a hit, each judged once
        setup('{16'h0040, 16'h0080, 1'h0, 16'h0000, 1'h0});
        start <= 1'h1;
        start_word <= 16'h0010;
        delay <= 4'h0;
        @(posedge sys_clk);
        start_word <= 16'h0050;
        @(posedge sys_clk);
        start <= 1'h0;
        repeat (5) @(posedge sys_clk);
        check(16'(window_match_flag), 16'h0001);
        // Interrupt raised, masked, cleared
        bus_wr(OFF_IRQ_CLEAR, 8'h03);
        bus_wr(OFF_IRQ_ENABLE, 8'h01);
        conv(16'h0050, 4'h3);
        @(posedge sys_clk);
        check(16'(irq), 16'h0001);
        bus_rd(OFF_IRQ_STATUS);
        check(16'(got), 16'h0003);
        bus_wr(OFF_IRQ_ENABLE, 8'h00);
        @(posedge sys_clk);
        check(16'(irq), 16'h0000);
        bus_wr(OFF_IRQ_CLEAR, 8'h01);
        bus_wr(OFF_IRQ_ENABLE, 8'h03);
        @(posedge sys_clk);
        check(16'(irq), 16'h0001);
        bus_wr(OFF_IRQ_CLEAR, 8'h02);
        @(posedge sys_clk);
        check(16'(irq), 16'h0000);
        bus_wr(OFF_CONTROL, 8'h00);
        @(posedge sys_clk);
        check(16'(window_match_flag), 16'h0000);
        // Second reset in mid-run restores the limits
        rst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        bus_rd(OFF_GREATER_HIGH);
        check(16'(got), 16'h00FF);
        end_sim;
    end
endmodule

`default_nettype wire

// *** src/adc_window_detector.sv ***
// Notes on behaviour
// - Compare each result against limits autonomously
// - Greater and lesser limits as byte pairs
// - Limit ordering alone picks inside or outside
// - Match flag in control, interrupt or polled
// - Single-ended results compared as unsigned
// - Greater below lesser flags strictly between
// - Otherwise flag above greater or below lesser
// - Differential results compared as two's complement
// - Signed window flags strictly between limits
// - Signed outside window flags beyond either limit
// - Result held in high and low bytes
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module adc_window_detector
    import adc_window_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire adc_window_pkg::reg_req_type req,
    output logic [adc_window_pkg::DATA_W-1:0] rdata,
    // Conversion results from the converter datapath
    input wire adc_window_pkg::result_type result,
    // Flag and interrupt
    output logic window_match_flag,
    output logic irq
);

    import adc_window_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Byte pairs must tile the compare word exactly
    if (WORD_W != 2 * DATA_W) begin
        $error("compare word must be two register bytes");
    end

    // Status and enable must fit one register byte
    if (IRQ_BITS > DATA_W) begin
        $error("interrupt status wider than a register byte");
    end

    // Flag positions must lie inside the control byte
    if (CTRL_MATCH_BIT >= DATA_W || CTRL_DONE_BIT >= DATA_W) begin
        $error("control flag outside the register byte");
    end

    // Mode select must lie inside the mode byte
    if (MODE_SIGNED_BIT >= DATA_W) begin
        $error("mode select bit outside the register byte");
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode

    logic wr_greater_high;
    logic wr_greater_low;
    logic wr_lesser_high;
    logic wr_lesser_low;
    logic wr_control;
    logic wr_mode;
    logic wr_irq_enable;
    logic wr_irq_clear;

    // Write strobes per register; result bytes ignore software writes
    always_comb begin
        wr_greater_high = req.wr && (req.addr == OFF_GREATER_HIGH);
        wr_greater_low = req.wr && (req.addr == OFF_GREATER_LOW);
        wr_lesser_high = req.wr && (req.addr == OFF_LESSER_HIGH);
        wr_lesser_low = req.wr && (req.addr == OFF_LESSER_LOW);
        wr_control = req.wr && (req.addr == OFF_CONTROL);
        wr_mode = req.wr && (req.addr == OFF_MODE);
        wr_irq_enable = req.wr && (req.addr == OFF_IRQ_ENABLE);
        wr_irq_clear = req.wr && (req.addr == OFF_IRQ_CLEAR);
    end

    ////////////////////////////////////////////////////////////////////////
    // Word registers

    logic [WORD_W-1:0] result_word;
    logic [WORD_W-1:0] greater_limit_pair;
    logic [WORD_W-1:0] lesser_limit_pair;

    // Result pair is loaded whole by the datapath only
    byte_pair_reg #(
        .BYTE_W(DATA_W),
        .RESET_VALUE(RESULT_RESET)
    ) u_result (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_high(1'b0),
        .wr_low(1'b0),
        .wdata(req.wdata),
        .load(result.valid),
        .load_word(result.word),
        .word(result_word)
    );

    // Greater-than limit, byte writable
    byte_pair_reg #(
        .BYTE_W(DATA_W),
        .RESET_VALUE(GREATER_RESET)
    ) u_greater (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_high(wr_greater_high),
        .wr_low(wr_greater_low),
        .wdata(req.wdata),
        .load(1'b0),
        .load_word(GREATER_RESET),
        .word(greater_limit_pair)
    );

    // Less-than limit, byte writable
    byte_pair_reg #(
        .BYTE_W(DATA_W),
        .RESET_VALUE(LESSER_RESET)
    ) u_lesser (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_high(wr_lesser_high),
        .wr_low(wr_lesser_low),
        .wdata(req.wdata),
        .load(1'b0),
        .load_word(LESSER_RESET),
        .word(lesser_limit_pair)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode

    logic [DATA_W-1:0] mode;
    logic signed_mode;

    // Differential data selects the signed compare
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode <= MODE_RESET;
        end else if (wr_mode) begin
            mode <= req.wdata;
        end
    end

    assign signed_mode = mode[MODE_SIGNED_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Comparison

    logic res_above_greater;
    logic res_below_lesser;
    logic greater_below_lesser;
    logic window_hit;

    // Result against greater-than limit
    limit_compare #(
        .WIDTH(WORD_W)
    ) u_cmp_greater (
        .a(result_word),
        .b(greater_limit_pair),
        .signed_mode(signed_mode),
        .a_above(res_above_greater),
        .a_below()
    );

    // Result against less-than limit
    limit_compare #(
        .WIDTH(WORD_W)
    ) u_cmp_lesser (
        .a(result_word),
        .b(lesser_limit_pair),
        .signed_mode(signed_mode),
        .a_above(),
        .a_below(res_below_lesser)
    );

    // Limit ordering decides inside versus outside
    limit_compare #(
        .WIDTH(WORD_W)
    ) u_cmp_order (
        .a(greater_limit_pair),
        .b(lesser_limit_pair),
        .signed_mode(signed_mode),
        .a_above(),
        .a_below(greater_below_lesser)
    );

    // Inside window needs both relations, outside needs either
    always_comb begin
        if (greater_below_lesser) begin
            window_hit = res_above_greater && res_below_lesser;
        end else begin
            window_hit = res_above_greater || res_below_lesser;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    seq_state_type state;
    seq_state_type next_state;
    logic match_event;
    logic done_event;

    // Evaluate in the cycle after each load, exactly once per result
    always_comb begin
        case (state)
            SEQ_IDLE: begin
                next_state = result.valid ? SEQ_EVAL : SEQ_IDLE;
            end
            SEQ_EVAL: begin
                next_state = result.valid ? SEQ_EVAL : SEQ_IDLE;
            end
            default: begin
                next_state = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= SEQ_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // No processor action needed between result and flag
    assign match_event = (state == SEQ_EVAL) && window_hit;
    assign done_event = (state == SEQ_EVAL);

    ////////////////////////////////////////////////////////////////////////
    // Converter control register

    logic [DATA_W-1:0] control;

    // Stored bits plus two flags; a new event wins over a software clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            control <= CONTROL_RESET;
        end else begin
            if (wr_control) begin
                control <= req.wdata & CTRL_STORED_MASK;
                control[CTRL_MATCH_BIT] <= req.wdata[CTRL_MATCH_BIT] || match_event;
                control[CTRL_DONE_BIT] <= req.wdata[CTRL_DONE_BIT] || done_event;
            end else begin
                if (match_event) begin
                    control[CTRL_MATCH_BIT] <= 1'b1;
                end
                if (done_event) begin
                    control[CTRL_DONE_BIT] <= 1'b1;
                end
            end
        end
    end

    // Polled copy of the match flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            window_match_flag <= 1'b0;
        end else begin
            window_match_flag <= control[CTRL_MATCH_BIT] || match_event;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts

    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_enable;
    logic [IRQ_BITS-1:0] irq_set;

    assign irq_set = {done_event, match_event};

    // Sticky status, write-one clear, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_status <= IRQ_RESET;
        end else if (wr_irq_clear) begin
            irq_status <= (irq_status & ~req.wdata[IRQ_BITS-1:0]) | irq_set;
        end else begin
            irq_status <= irq_status | irq_set;
        end
    end

    // Enable mask
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_enable <= IRQ_RESET;
        end else if (wr_irq_enable) begin
            irq_enable <= req.wdata[IRQ_BITS-1:0];
        end
    end

    // Level interrupt, one flop behind the status bits
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    logic [DATA_W-1:0] next_rdata;

    // Unmapped and write-only offsets read as zero; busy always reads zero
    always_comb begin
        next_rdata = READ_ZERO;
        if (req.rd) begin
            case (req.addr)
                OFF_CONTROL: next_rdata = control;
                OFF_RESULT_HIGH: next_rdata = result_word[WORD_W-1:DATA_W];
                OFF_RESULT_LOW: next_rdata = result_word[DATA_W-1:0];
                OFF_GREATER_HIGH: next_rdata = greater_limit_pair[WORD_W-1:DATA_W];
                OFF_GREATER_LOW: next_rdata = greater_limit_pair[DATA_W-1:0];
                OFF_LESSER_HIGH: next_rdata = lesser_limit_pair[WORD_W-1:DATA_W];
                OFF_LESSER_LOW: next_rdata = lesser_limit_pair[DATA_W-1:0];
                OFF_MODE: next_rdata = mode;
                OFF_IRQ_STATUS: next_rdata = {{(DATA_W-IRQ_BITS){1'b0}}, irq_status};
                OFF_IRQ_ENABLE: next_rdata = {{(DATA_W-IRQ_BITS){1'b0}}, irq_enable};
                default: next_rdata = READ_ZERO;
            endcase
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata <= READ_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// *** src/adc_window_pkg.sv ***
package adc_window_pkg;

    // Register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;

    // Register offsets
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_RESULT_HIGH = 4'h1;
    localparam logic [3:0] OFF_RESULT_LOW = 4'h2;
    localparam logic [3:0] OFF_GREATER_HIGH = 4'h3;
    localparam logic [3:0] OFF_GREATER_LOW = 4'h4;
    localparam logic [3:0] OFF_LESSER_HIGH = 4'h5;
    localparam logic [3:0] OFF_LESSER_LOW = 4'h6;
    localparam logic [3:0] OFF_MODE = 4'h7;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h8;
    localparam logic [3:0] OFF_IRQ_ENABLE = 4'h9;
    localparam logic [3:0] OFF_IRQ_CLEAR = 4'hA;

    // Converter control register fields
    localparam int CTRL_DONE_BIT = 5;
    localparam int CTRL_BUSY_BIT = 4;
    localparam int CTRL_MATCH_BIT = 3;
    localparam logic [7:0] CTRL_STORED_MASK = 8'hC7;

    // Mode register fields
    localparam int MODE_SIGNED_BIT = 0;

    // Interrupt status fields
    localparam int IRQ_MATCH_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam int IRQ_BITS = 2;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] GREATER_RESET = 16'hFFFF;
    localparam logic [15:0] LESSER_RESET = 16'h0000;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    // New conversion word from the converter datapath
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } result_type;

    // Comparison sequencer
    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_EVAL = 1'b1
    } seq_state_type;

endpackage

// *** src/byte_pair_reg.sv ***
`timescale 1ns/1ns
`default_nettype none

module byte_pair_reg #(
    parameter int BYTE_W = 8,
    parameter logic [2*BYTE_W-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Byte writes from software
    input wire logic wr_high,
    input wire logic wr_low,
    input wire logic [BYTE_W-1:0] wdata,
    // Whole-word load from hardware
    input wire logic load,
    input wire logic [2*BYTE_W-1:0] load_word,
    // Stored word
    output logic [2*BYTE_W-1:0] word
);

    if (BYTE_W < 1) begin
        $error("byte_pair_reg needs a positive byte width");
    end

    // Whole-word load beats byte writes so a fresh result is never torn
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            word <= RESET_VALUE;
        end else if (load) begin
            word <= load_word;
        end else begin
            if (wr_high) begin
                word[2*BYTE_W-1:BYTE_W] <= wdata;
            end
            if (wr_low) begin
                word[BYTE_W-1:0] <= wdata;
            end
        end
    end

endmodule

`default_nettype wire

// *** src/limit_compare.sv ***
`timescale 1ns/1ns
`default_nettype none

module limit_compare #(
    parameter int WIDTH = 16
) (
    // Operands, compared as raw register words
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    input wire logic signed_mode,
    // Strict relations
    output logic a_above,
    output logic a_below
);

    if (WIDTH < 2) begin
        $error("limit_compare needs at least two bits");
    end

    // Signed compare of the full word also suits left-justified data
    always_comb begin
        if (signed_mode) begin
            a_above = $signed(a) > $signed(b);
            a_below = $signed(a) < $signed(b);
        end else begin
            a_above = a > b;
            a_below = a < b;
        end
    end

endmodule

`default_nettype wire
